// ===== shared/tri_pwm_map.vh
// register map, field positions, reset values and widths of the triangle pwm channel
`ifndef TRI_PWM_MAP_VH
`define TRI_PWM_MAP_VH

`define CNT_W            16
`define ADDR_W           8

// register byte addresses
`define OFF_CTRL         8'h00
`define OFF_PERIOD       8'h04
`define OFF_POS_BUF      8'h08
`define OFF_NEG_BUF      8'h0c
`define OFF_PRESCALE     8'h10
`define OFF_STATUS       8'h14
`define OFF_COUNT        8'h18
`define OFF_POS_CMP      8'h1c
`define OFF_NEG_CMP      8'h20
`define OFF_INT_STAT     8'h24
`define OFF_INT_CLR      8'h28
`define OFF_INT_EN       8'h2c

// control register fields
`define CTRL_RUN         0
`define CTRL_MODE_LO     1
`define CTRL_MODE_HI     2
`define CTRL_AUTO_DT     3
`define CTRL_FDS_LO      4
`define CTRL_FDS_HI      5
`define CTRL_REL_SEL     6
`define CTRL_CES_LO      7
`define CTRL_CES_HI      8
`define CTRL_W           9

// forced duty codes
`define FDS_NONE         2'h0
`define FDS_ZERO         2'h2
`define FDS_FULL         2'h3

// cycle end output selection codes
`define CES_TOGGLE       2'h0
`define CES_LOW          2'h1
`define CES_HIGH         2'h2

// protection state codes as read back
`define PS_NORMAL        2'h0
`define PS_TRANSITION    2'h1
`define PS_PROTECTED     2'h2
`define PS_RETURN        2'h3

// interrupt bit positions
`define IRQ_TROUGH       0
`define IRQ_CREST        1
`define IRQ_PROT_ENTER   2
`define IRQ_PROT_EXIT    3
`define IRQ_W            4

// reset values
`define RST_CTRL         9'h002
`define RST_PERIOD       16'h00ff
`define RST_POS_BUF      16'h0080
`define RST_NEG_BUF      16'h0080
`define RST_PRESCALE     8'h00

`endif

// ===== design/tri_pwm_forced_duty_protect.v
// triangle-wave complementary pwm channel with forced 0%/100% duty and output protection
//
// Decided for this implementation: the address map and the strobed register port.
`include "tri_pwm_map.vh"

module tri_pwm_forced_duty_protect (
   // clock and reset
   input  wire                 clock_in,
   input  wire                 rst_in,
   // register port
   input  wire [`ADDR_W-1:0]   addr_in,
   input  wire [31:0]          wr_data_in,
   input  wire                 wr_in,
   input  wire                 rd_in,
   output reg  [31:0]          rd_data_out,
   // pwm pins
   output reg                  pos_pwm_pin_out,
   output reg                  pos_pwm_pin_oe_out,
   output reg                  neg_pwm_pin_out,
   output reg                  neg_pwm_pin_oe_out,
   // group protection and interrupt
   output reg                  protect_disable_out,
   output reg                  irq_out
);

   localparam [3:0] ST_NORMAL = 4'h1;
   localparam [3:0] ST_TRANS  = 4'h2;
   localparam [3:0] ST_PROT   = 4'h4;
   localparam [3:0] ST_RET    = 4'h8;

   // readable code of a one-hot protection state
   function [1:0] state_code;
      input [3:0] st;
      begin
         case (st)
            ST_TRANS: state_code = `PS_TRANSITION;
            ST_PROT:  state_code = `PS_PROTECTED;
            ST_RET:   state_code = `PS_RETURN;
            default:  state_code = `PS_NORMAL;
         endcase
      end
   endfunction

   // forced duty code to fixed level, or none
   function is_force;
      input [1:0] code;
      begin
         is_force = (code == `FDS_FULL) || (code == `FDS_ZERO);
      end
   endfunction

   reg [`CTRL_W-1:0]   ctrl_q;
   reg [`CNT_W-1:0]    period_q;
   reg [`CNT_W-1:0]    pos_buf_q;
   reg [`CNT_W-1:0]    neg_buf_q;
   reg [7:0]           prescale_q;
   reg [7:0]           div_q;
   reg [`CNT_W-1:0]    cnt_q;
   reg                 down_q;
   reg [`CNT_W-1:0]    pos_cmp_q;
   reg [`CNT_W-1:0]    neg_cmp_q;
   reg [1:0]           force_q;
   reg                 pre_lvl_q;
   reg [3:0]           state_q;
   reg                 abn_zero_q;
   reg                 abn_crest_q;
   reg [`IRQ_W-1:0]    int_stat_q;
   reg [`IRQ_W-1:0]    int_en_q;

   wire                run      = ctrl_q[`CTRL_RUN];
   wire [1:0]          mode     = ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO];
   wire                auto_dt  = ctrl_q[`CTRL_AUTO_DT];
   wire [1:0]          fds      = ctrl_q[`CTRL_FDS_HI:`CTRL_FDS_LO];
   wire                rel_sel  = ctrl_q[`CTRL_REL_SEL];
   wire [1:0]          ces      = ctrl_q[`CTRL_CES_HI:`CTRL_CES_LO];

   // one count clock: enable pulse from the prescaler
   wire                tick     = run && (div_q == prescale_q);
   wire                crest    = tick && !down_q && (cnt_q == period_q);
   wire                trough   = tick && down_q && (cnt_q == {`CNT_W{1'b0}});
   // mode 1 reloads at the trough only, modes 2 and 3 at both ends
   wire                xfer     = trough || (crest && (mode != 2'h1));
   wire                forced   = is_force(force_q);
   wire                pos_match = tick && (cnt_q == pos_cmp_q);
   wire                neg_match = tick && (cnt_q == neg_cmp_q);

   // normal window is strictly between zero and the period
   wire                buf_zero = (pos_buf_q == {`CNT_W{1'b0}});
   wire                buf_abn  = buf_zero || (pos_buf_q >= period_q);
   // mode 0 is not a triangle mode and never protects
   wire                prot_en  = auto_dt && (mode != 2'h0);

   wire                wr_ctrl  = wr_in && (addr_in == `OFF_CTRL);

   // register writes
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_q     <= `RST_CTRL;
         period_q   <= `RST_PERIOD;
         pos_buf_q  <= `RST_POS_BUF;
         neg_buf_q  <= `RST_NEG_BUF;
         prescale_q <= `RST_PRESCALE;
         int_en_q   <= {`IRQ_W{1'b0}};
      end else if (wr_in) begin
         case (addr_in)
            `OFF_CTRL:     ctrl_q     <= wr_data_in[`CTRL_W-1:0];
            `OFF_PERIOD:   period_q   <= wr_data_in[`CNT_W-1:0];
            `OFF_POS_BUF:  pos_buf_q  <= wr_data_in[`CNT_W-1:0];
            `OFF_NEG_BUF:  neg_buf_q  <= wr_data_in[`CNT_W-1:0];
            `OFF_PRESCALE: prescale_q <= wr_data_in[7:0];
            `OFF_INT_EN:   int_en_q   <= wr_data_in[`IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // prescaler and up/down counter
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         div_q  <= 8'h00;
         cnt_q  <= {`CNT_W{1'b0}};
         down_q <= 1'b0;
      end else if (!run) begin
         div_q <= 8'h00;
      end else begin
         div_q <= tick ? 8'h00 : div_q + 8'h01;
         if (tick) begin
            if (crest) begin
               down_q <= 1'b1;
               cnt_q  <= cnt_q - {{(`CNT_W-1){1'b0}}, 1'b1};
            end else if (trough) begin
               down_q <= 1'b0;
               cnt_q  <= cnt_q + {{(`CNT_W-1){1'b0}}, 1'b1};
            end else if (down_q) begin
               cnt_q  <= cnt_q - {{(`CNT_W-1){1'b0}}, 1'b1};
            end else begin
               cnt_q  <= cnt_q + {{(`CNT_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   // buffer to compare transfer
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         pos_cmp_q <= `RST_POS_BUF;
         neg_cmp_q <= `RST_NEG_BUF;
      end else if (xfer) begin
         pos_cmp_q <= pos_buf_q;
         neg_cmp_q <= neg_buf_q;
      end
   end

   // level the positive phase takes when forced duty ends
   reg rel_lvl;
   always @* begin
      rel_lvl = pre_lvl_q;
      if (rel_sel) begin
         rel_lvl = pre_lvl_q;
      end else begin
         case (ces)
            `CES_TOGGLE: rel_lvl = ~pre_lvl_q;
            `CES_LOW:    rel_lvl = 1'b0;
            `CES_HIGH:   rel_lvl = 1'b1;
            default:     rel_lvl = pos_pwm_pin_out;
         endcase
      end
   end

   // phase levels; forced duty is sampled and released only at the trough
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         force_q         <= `FDS_NONE;
         pre_lvl_q       <= 1'b0;
         pos_pwm_pin_out <= 1'b0;
         neg_pwm_pin_out <= 1'b1;
      end else if (trough && (is_force(fds) != forced || (forced && fds != force_q))) begin
         force_q <= is_force(fds) ? fds : `FDS_NONE;
         if (is_force(fds)) begin
            if (!forced) begin
               pre_lvl_q <= pos_pwm_pin_out;
            end
            // complementary fixed levels with no dead time gap
            pos_pwm_pin_out <= (fds == `FDS_FULL);
            neg_pwm_pin_out <= (fds != `FDS_FULL);
         end else begin
            pos_pwm_pin_out <= rel_lvl;
            neg_pwm_pin_out <= ~rel_lvl;
         end
      end else if (!forced) begin
         // exact equality keeps even one-count pulses near the period
         if (pos_match) begin
            pos_pwm_pin_out <= ~pos_pwm_pin_out;
         end
         if (neg_match) begin
            neg_pwm_pin_out <= ~neg_pwm_pin_out;
         end
      end
   end

   // output protection state machine, stepped at value transfers; the transition and return states step at every crest and trough
   reg [3:0] state_d;
   always @* begin
      state_d = state_q;
      if (!prot_en) begin
         state_d = ST_NORMAL;
      end else begin
         case (state_q)
            ST_NORMAL: begin
               if (xfer && buf_abn) begin
                  // zero passes a transition interval, at/above period goes straight in
                  state_d = buf_zero ? ST_TRANS : ST_PROT;
               end
            end
            ST_TRANS: begin
               if (crest || trough) begin
                  state_d = ST_PROT;
               end
            end
            ST_PROT: begin
               if (xfer && !buf_abn) begin
                  if (abn_zero_q ? trough : (abn_crest_q != crest)) begin
                     state_d = ST_RET;
                  end else begin
                     state_d = ST_NORMAL;
                  end
               end
            end
            ST_RET: begin
               if (crest || trough) begin
                  state_d = ST_NORMAL;
               end
            end
            default: state_d = ST_NORMAL;
         endcase
      end
   end

   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         state_q     <= ST_NORMAL;
         abn_zero_q  <= 1'b0;
         abn_crest_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_q == ST_NORMAL && state_d != ST_NORMAL) begin
            abn_zero_q  <= buf_zero;
            abn_crest_q <= crest;
         end
      end
   end

   // pins float in the protected state and while stopped; the transition interval keeps toggling
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         pos_pwm_pin_oe_out  <= 1'b0;
         neg_pwm_pin_oe_out  <= 1'b0;
         protect_disable_out <= 1'b0;
      end else begin
         pos_pwm_pin_oe_out  <= run && (state_d != ST_PROT);
         neg_pwm_pin_oe_out  <= run && (state_d != ST_PROT);
         protect_disable_out <= (state_d == ST_PROT);
      end
   end

   // interrupt events; a set in the clear cycle wins
   wire [`IRQ_W-1:0] evt;
   assign evt[`IRQ_TROUGH]     = trough;
   assign evt[`IRQ_CREST]      = crest;
   assign evt[`IRQ_PROT_ENTER] = (state_q != ST_PROT) && (state_d == ST_PROT);
   assign evt[`IRQ_PROT_EXIT]  = (state_q != ST_NORMAL) && (state_d == ST_NORMAL);

   wire clr_hit = wr_in && (addr_in == `OFF_INT_CLR);

   genvar i;
   generate
      for (i = 0; i < `IRQ_W; i = i + 1) begin : g_irq
         always @(posedge clock_in or posedge rst_in) begin
            if (rst_in) begin
               int_stat_q[i] <= 1'b0;
            end else if (evt[i]) begin
               int_stat_q[i] <= 1'b1;
            end else if (clr_hit && wr_data_in[i]) begin
               int_stat_q[i] <= 1'b0;
            end
         end
      end
   endgenerate

   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |((int_stat_q | evt) & int_en_q & ~(clr_hit ? wr_data_in[`IRQ_W-1:0] & ~evt : {`IRQ_W{1'b0}}))
                    || (|(evt & int_en_q));
      end
   end

   // read data one cycle after the strobe, zero otherwise
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h0000_0000;
      case (addr_in)
         `OFF_CTRL:     rd_mux[`CTRL_W-1:0] = ctrl_q;
         `OFF_PERIOD:   rd_mux[`CNT_W-1:0]  = period_q;
         `OFF_POS_BUF:  rd_mux[`CNT_W-1:0]  = pos_buf_q;
         `OFF_NEG_BUF:  rd_mux[`CNT_W-1:0]  = neg_buf_q;
         `OFF_PRESCALE: rd_mux[7:0]         = prescale_q;
         `OFF_STATUS:   rd_mux[5:0]         = {neg_pwm_pin_out, pos_pwm_pin_out, down_q, forced,
                                               state_code(state_q)};
         `OFF_COUNT:    rd_mux[`CNT_W-1:0]  = cnt_q;
         `OFF_POS_CMP:  rd_mux[`CNT_W-1:0]  = pos_cmp_q;
         `OFF_NEG_CMP:  rd_mux[`CNT_W-1:0]  = neg_cmp_q;
         `OFF_INT_STAT: rd_mux[`IRQ_W-1:0]  = int_stat_q;
         `OFF_INT_EN:   rd_mux[`IRQ_W-1:0]  = int_en_q;
         default:       rd_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         rd_data_out <= 32'h0000_0000;
      end else begin
         rd_data_out <= rd_in ? rd_mux : 32'h0000_0000;
      end
   end

endmodule

// ===== test/tri_pwm_checker_sva.sv
// port-level assertions for the triangle pwm channel
`include "tri_pwm_map.vh"
module tri_pwm_checker (
   // clock and reset
   input wire               clock_in,
   input wire               rst_in,
   // register port
   input wire [`ADDR_W-1:0] addr_in,
   input wire [31:0]        wr_data_in,
   input wire               wr_in,
   input wire               rd_in,
   input wire [31:0]        rd_data_out,
   // pins, protection and interrupt
   input wire               pos_pwm_pin_out,
   input wire               pos_pwm_pin_oe_out,
   input wire               neg_pwm_pin_out,
   input wire               neg_pwm_pin_oe_out,
   input wire               protect_disable_out,
   input wire               irq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // shadows of the control, prescale and interrupt enable fields the checks depend on, taken from bus writes
   reg              dt_q;
   reg              run_q;
   reg              slow_q;
   reg [`IRQ_W-1:0] en_q;
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         dt_q   <= 1'b0;
         run_q  <= 1'b0;
         slow_q <= 1'b0;
         en_q   <= '0;
      end else if (wr_in) begin
         if (addr_in == `OFF_CTRL) begin
            dt_q  <= wr_data_in[`CTRL_AUTO_DT];
            run_q <= wr_data_in[`CTRL_RUN];
         end
         if (addr_in == `OFF_PRESCALE)
            slow_q <= |wr_data_in[7:0];
         if (addr_in == `OFF_INT_EN)
            en_q <= wr_data_in[`IRQ_W-1:0];
      end
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   a_rd_idle_zero: assert property (!rd_in |=> rd_data_out == 32'h0)
      else $error("read data not zero outside a read");
   a_rd_unmapped_zero: assert property (rd_in && addr_in == 8'h30 |=> rd_data_out == 32'h0)
      else $error("unmapped read not zero");
   a_clr_reads_zero: assert property (rd_in && addr_in == `OFF_INT_CLR |=> rd_data_out == 32'h0)
      else $error("clear register read not zero");
   a_prot_pins_off: assert property (protect_disable_out |-> !pos_pwm_pin_oe_out && !neg_pwm_pin_oe_out)
      else $error("pins driven while protected");
   a_oe_pair_equal: assert property (pos_pwm_pin_oe_out == neg_pwm_pin_oe_out)
      else $error("pin enables differ");
   a_no_prot_dtoff: assert property (!dt_q [*4] |-> !protect_disable_out)
      else $error("protection with auto dead time off");
   a_irq_masked_low: assert property ((en_q == 4'h0) [*3] |-> !irq_out)
      else $error("interrupt with all sources masked");
   a_stop_pins_still: assert property (!run_q [*3] |-> $stable(pos_pwm_pin_out) && $stable(neg_pwm_pin_out))
      else $error("pins moved while stopped");
   a_one_change_tick: assert property (slow_q && $changed(pos_pwm_pin_out) |=> $stable(pos_pwm_pin_out))
      else $error("positive pin changed twice in one tick");
endmodule
bind tri_pwm_forced_duty_protect tri_pwm_checker u_tri_pwm_checker (.clock_in, .rst_in, .addr_in, .wr_data_in,
   .wr_in, .rd_in, .rd_data_out, .pos_pwm_pin_out, .pos_pwm_pin_oe_out, .neg_pwm_pin_out, .neg_pwm_pin_oe_out,
   .protect_disable_out, .irq_out);

// ===== test/gate_drive_model.sv
// gate driver pair: resolves each pin onto a pulled-down gate line and counts gate edges
module gate_drive_model (
   // clock
   input  wire clock_in,
   // pins from the channel
   input  wire pos_level_in,
   input  wire pos_oe_in,
   input  wire neg_level_in,
   input  wire neg_oe_in,
   // resolved gates and edge counts
   output wire pos_gate_out,
   output wire neg_gate_out,
   output int  pos_edges_out,
   output int  neg_edges_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pos_l = 1'b0;
   logic neg_l = 1'b0;
   // one driver per count: the ports follow internal counters
   int   pos_n = 0;
   int   neg_n = 0;
   // a released pin is pulled low so the gate is off, never a stale level
   assign pos_gate_out = pos_oe_in ? pos_level_in : 1'b0;
   assign neg_gate_out = neg_oe_in ? neg_level_in : 1'b0;
   assign pos_edges_out = pos_n;
   assign neg_edges_out = neg_n;
   always @(posedge clock_in) begin
      if (pos_gate_out !== pos_l)
         pos_n <= pos_n + 1;
      if (neg_gate_out !== neg_l)
         neg_n <= neg_n + 1;
      pos_l <= pos_gate_out;
      neg_l <= neg_gate_out;
   end
endmodule

// ===== test/tb_top.sv
// self-checking bench for the triangle pwm channel
`include "tri_pwm_map.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P = 8;
   logic               clock_in = 1'b0;
   logic               rst_in = 1'b1;
   logic [`ADDR_W-1:0] addr_in = '0;
   logic [31:0]        wr_data_in = '0;
   logic               wr_in = 1'b0;
   logic               rd_in = 1'b0;
   wire  [31:0]        rd_data_out;
   wire                pos_pwm_pin_out, pos_pwm_pin_oe_out, neg_pwm_pin_out, neg_pwm_pin_oe_out;
   wire                protect_disable_out, irq_out, pos_gate, neg_gate;
   int                 pos_edges, neg_edges, c, e, f, t0, t1;
   int                 fail_count = 0;
   int                 total_checks = 0;
   int                 cyc = 0;
   logic [31:0]        d;
   logic [1:0]         fds;
   logic               pre;
   tri_pwm_forced_duty_protect u_tri_pwm_forced_duty_protect (.clock_in, .rst_in, .addr_in, .wr_data_in, .wr_in,
      .rd_in, .rd_data_out, .pos_pwm_pin_out, .pos_pwm_pin_oe_out, .neg_pwm_pin_out, .neg_pwm_pin_oe_out,
      .protect_disable_out, .irq_out);
   gate_drive_model u_gate_drive_model (.clock_in, .pos_level_in(pos_pwm_pin_out), .pos_oe_in(pos_pwm_pin_oe_out),
      .neg_level_in(neg_pwm_pin_out), .neg_oe_in(neg_pwm_pin_oe_out), .pos_gate_out(pos_gate),
      .neg_gate_out(neg_gate), .pos_edges_out(pos_edges), .neg_edges_out(neg_edges));
   always #20 clock_in = ~clock_in;
   task automatic summarize();
      if (fail_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 30000) begin
         fail_count++;
         summarize();
      end
   end
   task automatic chk(input [31:0] seen, input [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input [7:0] a, input [31:0] v);
      @(posedge clock_in);
      addr_in <= a;
      wr_data_in <= v;
      wr_in <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input [7:0] a, output [31:0] v);
      @(posedge clock_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clock_in);
      rd_in <= 1'b0;
      #1 v = rd_data_out;
   endtask
   // trough flag cleared first so a stale event is never taken for the next one
   task automatic wait_trough();
      int n;
      wr(`OFF_INT_CLR, 32'h1);
      repeat (2) @(posedge clock_in);
      #1 n = 0;
      while (irq_out !== 1'b1 && n < 400) begin
         @(posedge clock_in);
         #1 n++;
      end
      if (n == 400)
         fail_count++;
      repeat (2) @(posedge clock_in);
      #1;
   endtask
   task automatic next_change(output int t);
      logic v;
      int   n;
      v = pos_gate;
      n = 0;
      while (pos_gate === v && n < 300) begin
         @(posedge clock_in);
         #1 n++;
      end
      t = cyc;
   endtask
   function automatic [31:0] ctl(input [1:0] mode, input dt, input [1:0] fd);
      ctl = {23'h0, 2'b00, 1'b0, fd, dt, mode, 1'b1};
   endfunction
   initial begin
      void'($urandom(32'h01302da4));
      repeat (6) @(posedge clock_in);
      rst_in <= 1'b0;
      rd(`OFF_CTRL, d);
      chk(d, {23'h0, `RST_CTRL});
      rd(`OFF_PERIOD, d);
      chk(d, {16'h0, `RST_PERIOD});
      rd(`OFF_POS_BUF, d);
      chk(d, {16'h0, `RST_POS_BUF});
      rd(8'h30, d);
      chk(d, 32'h0);
      wr(`OFF_STATUS, 32'h3);
      rd(`OFF_STATUS, d);
      chk(d & 32'h37, 32'h20);
      chk({pos_pwm_pin_out, neg_pwm_pin_out, pos_pwm_pin_oe_out, neg_pwm_pin_oe_out}, 4'b0100);
      wr(`OFF_PERIOD, P);
      rd(`OFF_PERIOD, d);
      chk(d, P);
      wr(`OFF_PRESCALE, 32'h7);
      wr(`OFF_INT_EN, 32'h1);
      // tick every 8 clocks: a pulse spans 16 clocks per count between match and crest and back
      for (int m = 1; m < 4; m++) begin
         for (int k = 0; k < 2; k++) begin
            c = (k == 0) ? P - 1 : 1 + $urandom % (P - 1);
            wr(`OFF_POS_BUF, c);
            wr(`OFF_NEG_BUF, 1 + $urandom % (P - 1));
            wr(`OFF_CTRL, ctl(m[1:0], 1'b0, `FDS_NONE));
            wait_trough();
            wait_trough();
            next_change(t0);
            next_change(t1);
            chk(t1 - t0, 16 * (P - c));
            wait_trough();
            e = pos_edges;
            f = neg_edges;
            wait_trough();
            chk(pos_edges - e, 2);
            chk(neg_edges - f, 2);
         end
      end
      for (int m = 1; m < 4; m++) begin
         for (int k = 0; k < 2; k++) begin
            fds = k ? `FDS_ZERO : `FDS_FULL;
            wait_trough();
            pre = pos_gate;
            wr(`OFF_CTRL, ctl(m[1:0], 1'b0, fds));
            rd(`OFF_STATUS, d);
            chk(d[2], 1'b0);
            wait_trough();
            e = pos_edges;
            chk(pos_gate, fds == `FDS_FULL);
            chk(neg_gate, fds != `FDS_FULL);
            wait_trough();
            chk(pos_edges - e, 0);
            wr(`OFF_CTRL, ctl(m[1:0], 1'b0, `FDS_NONE));
            rd(`OFF_STATUS, d);
            chk(d[2], 1'b1);
            wait_trough();
            chk(pos_gate, !pre);
            e = pos_edges;
            wait_trough();
            chk(pos_edges - e, 2);
         end
      end
      // release select 1 restores the pre-force level; cycle end 01b drives low
      for (int r = 0; r < 2; r++) begin
         wait_trough();
         pre = pos_gate;
         wr(`OFF_CTRL, ctl(2'd1, 1'b0, `FDS_FULL) | (r ? 32'h80 : 32'h40));
         wait_trough();
         wr(`OFF_CTRL, ctl(2'd1, 1'b0, `FDS_NONE) | (r ? 32'h80 : 32'h40));
         wait_trough();
         chk(pos_gate, r ? 1'b0 : pre);
      end
      wr(`OFF_CTRL, ctl(2'd1, 1'b1, `FDS_NONE));
      wr(`OFF_POS_BUF, 32'h0);
      wait_trough();
      rd(`OFF_STATUS, d);
      chk(d[1:0], `PS_TRANSITION);
      chk({protect_disable_out, pos_pwm_pin_oe_out, neg_pwm_pin_oe_out}, 3'b011);
      wait_trough();
      rd(`OFF_STATUS, d);
      chk(d[1:0], `PS_PROTECTED);
      chk({protect_disable_out, pos_gate, neg_gate}, 3'b100);
      wr(`OFF_POS_BUF, P / 2);
      wait_trough();
      rd(`OFF_STATUS, d);
      chk(d[1:0], `PS_RETURN);
      wait_trough();
      rd(`OFF_STATUS, d);
      chk({protect_disable_out, d[1:0]}, {1'b0, `PS_NORMAL});
      wr(`OFF_POS_BUF, P);
      wait_trough();
      rd(`OFF_STATUS, d);
      chk(d[1:0], `PS_PROTECTED);
      wr(`OFF_POS_BUF, P / 2);
      wait_trough();
      rd(`OFF_STATUS, d);
      chk(d[1:0], `PS_NORMAL);
      wr(`OFF_CTRL, ctl(2'd1, 1'b0, `FDS_NONE));
      wr(`OFF_POS_BUF, 32'h0);
      wait_trough();
      wait_trough();
      rd(`OFF_STATUS, d);
      chk({protect_disable_out, d[1:0]}, {1'b0, `PS_NORMAL});
      // mode 0 is not a triangle mode: a zero compare never protects there
      wr(`OFF_CTRL, ctl(2'd0, 1'b1, `FDS_NONE));
      wait_trough();
      rd(`OFF_STATUS, d);
      chk({protect_disable_out, d[1:0]}, {1'b0, `PS_NORMAL});
      rd(`OFF_INT_STAT, d);
      chk(d[3:0], 4'hf);
      chk(irq_out, 1'b1);
      wr(`OFF_INT_EN, 32'h0);
      repeat (3) @(posedge clock_in);
      #1 chk(irq_out, 1'b0);
      wr(`OFF_INT_CLR, 32'hf);
      rd(`OFF_INT_STAT, d);
      chk(d[0], 1'b0);
      summarize();
   end
endmodule
